/* adsc_ctrl.sv */
// adsc_ctrl: axi4-lite register file and sequencer of the 12-bit converter.
// assumes the analog comparator and input mux sit outside; comparator pin is
// asynchronous and is synchronised here.
//
// Implementation choices: the placing of the registers and the AXI4-Lite slave port.
`default_nettype none

// Summary of operation
// (R1) thirteen inputs selectable, each conversion yields a 12-bit result
// (R2) bits 5..2 of conversion_control pick input 0..12 in binary
// (R3) codes 1101..1111 select no input; conversion still runs, value floats
// (R4) bit 1 is start/busy status, bit 0 powers the converter
// (R5) port config bit 5 selects negative reference, bit 4 positive reference
// (R6) bits 3..0 set analog or digital per input, 0011 makes input 12 digital
// (R7) third register picks clock source, acquisition delay and justification; the clock field only flags the rc clock, bit-time is fixed at aclk/4
// (R8) six software registers: result high and low, three controls, status
// (R9) on completion load result, clear start bit, set done flag
// (R10) reset returns registers to defaults, converter off, conversion aborted
// (R11) software waits two bit-times between conversions
// (R12) internal rc clock adds one instruction cycle before conversion starts
// (R13) start while disabled is ignored and status stays clear
module adsc_ctrl (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// axi4-lite write address
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	// axi4-lite write data
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// axi4-lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read address
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	// axi4-lite read data
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// analog front end
	input wire logic comp_in,
	output logic [3:0] chan_sel,
	output logic chan_valid,
	output logic [11:0] dac_trial,
	output logic sample_hold,
	output logic converter_power,
	output logic neg_ref_select,
	output logic pos_ref_select,
	output logic [12:0] pin_analog,
	output logic conversion_done_flag
);
	import adsc_pkg::*;

	// register and control state
	logic [7:0] conv_ctrl_reg, conv_ctrl_next;
	logic [7:0] port_cfg_reg, port_cfg_next;
	logic [7:0] timing_reg, timing_next;
	logic [11:0] result_reg, result_next;
	logic done_reg, done_next;
	adsc_state_e state_reg, state_next;
	logic [4:0] acq_cnt_reg, acq_cnt_next;
	logic [7:0] rc_cnt_reg, rc_cnt_next;
	logic sar_start_reg, sar_start_next;
	// bus state
	logic awready_reg, awready_next, wready_reg, wready_next;
	logic aw_held_reg, aw_held_next, w_held_reg, w_held_next;
	logic [7:0] awaddr_reg, awaddr_next;
	logic [31:0] wdata_reg, wdata_next;
	logic [3:0] wstrb_reg, wstrb_next;
	logic bvalid_reg, bvalid_next;
	logic [1:0] bresp_reg, bresp_next;
	logic arready_reg, arready_next, rvalid_reg, rvalid_next;
	logic [31:0] rdata_reg, rdata_next;
	logic [1:0] rresp_reg, rresp_next;
	// pin synchroniser and outputs
	logic comp_meta_reg, comp_sync_reg;
	logic [12:0] pin_analog_reg, pin_analog_next;
	// helpers
	logic tick, sar_done, run_ticks, do_write;
	logic [11:0] sar_trial;
	logic [2:0] acq_code;
	logic [4:0] acq_len;
	logic rc_sel;

	// comparator pin passes two flops before anything reads it
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			comp_meta_reg <= 1'b0;
			comp_sync_reg <= 1'b0;
		end else begin
			comp_meta_reg <= comp_in;
			comp_sync_reg <= comp_meta_reg;
		end
	end

	// ticks restart with the sar, so each trial clears the synchroniser first
	assign run_ticks = ((state_reg == ADSC_ACQ) && (acq_cnt_reg != 5'd0)) ||
		((state_reg == ADSC_CONV) && !sar_start_reg);

	adsc_tick_gen u_tick (
		.aclk(aclk),
		.aresetn(aresetn),
		.run(run_ticks),
		.divide(ADSC_DEF_DIVIDE),
		.tick(tick)
	);

	adsc_sar u_sar (
		.aclk(aclk),
		.aresetn(aresetn),
		.start(sar_start_reg),
		.step(tick && (state_reg == ADSC_CONV)),
		.comp_in(comp_sync_reg),
		.trial(sar_trial),
		.done(sar_done)
	);

	// acquisition length in bit-times, code 0..7 -> 0,2,4,6,8,12,16,20
	assign acq_code = timing_reg[ADSC_ACQ_MSB:ADSC_ACQ_LSB];
	always_comb begin
		case (acq_code)
			3'h0: acq_len = 5'd0;
			3'h1: acq_len = 5'd2;
			3'h2: acq_len = 5'd4;
			3'h3: acq_len = 5'd6;
			3'h4: acq_len = 5'd8;
			3'h5: acq_len = 5'd12;
			3'h6: acq_len = 5'd16;
			default: acq_len = 5'd20;
		endcase
	end
	assign rc_sel = (timing_reg[ADSC_CLK_MSB:ADSC_CLK_LSB] == ADSC_CLK_RC) ||
		(timing_reg[ADSC_CLK_MSB:ADSC_CLK_LSB] == ADSC_CLK_RC_ALT);

	assign do_write = aw_held_reg && w_held_reg && !bvalid_reg;

	// axi write side: address and data taken in either order, reply after both
	always_comb begin
		awready_next = 1'b0;
		wready_next = 1'b0;
		aw_held_next = aw_held_reg;
		w_held_next = w_held_reg;
		awaddr_next = awaddr_reg;
		wdata_next = wdata_reg;
		wstrb_next = wstrb_reg;
		bvalid_next = bvalid_reg;
		bresp_next = bresp_reg;
		if (s_axi_awvalid && awready_reg) begin
			aw_held_next = 1'b1;
			awaddr_next = s_axi_awaddr;
		end
		if (s_axi_wvalid && wready_reg) begin
			w_held_next = 1'b1;
			wdata_next = s_axi_wdata;
			wstrb_next = s_axi_wstrb;
		end
		if (do_write) begin
			aw_held_next = 1'b0;
			w_held_next = 1'b0;
			bvalid_next = 1'b1;
			bresp_next = (awaddr_reg == ADSC_OFF_CONV_CTRL ||
				awaddr_reg == ADSC_OFF_PORT_CFG ||
				awaddr_reg == ADSC_OFF_TIMING ||
				awaddr_reg == ADSC_OFF_RESULT_HIGH ||
				awaddr_reg == ADSC_OFF_RESULT_LOW ||
				awaddr_reg == ADSC_OFF_STATUS) ?
				ADSC_RESP_OKAY : ADSC_RESP_SLVERR;
		end
		if (bvalid_reg && s_axi_bready) begin
			bvalid_next = 1'b0;
		end
		// one-cycle ready pulses; never offered while a slot is full
		awready_next = !aw_held_next && !awready_reg && s_axi_awvalid &&
			!bvalid_next;
		wready_next = !w_held_next && !wready_reg && s_axi_wvalid &&
			!bvalid_next;
	end

	// axi read side: one read at a time, data registered
	always_comb begin
		arready_next = 1'b0;
		rvalid_next = rvalid_reg;
		rdata_next = rdata_reg;
		rresp_next = rresp_reg;
		if (rvalid_reg && s_axi_rready) begin
			rvalid_next = 1'b0;
		end
		if (s_axi_arvalid && arready_reg) begin
			rvalid_next = 1'b1;
			rresp_next = ADSC_RESP_OKAY;
			rdata_next = 32'h0000_0000;
			// justification applies to what software sees; see (R7)
			case (s_axi_araddr)
				ADSC_OFF_RESULT_HIGH: rdata_next[7:0] =
					timing_reg[ADSC_JUST_BIT] ? {4'h0, result_reg[11:8]} :
					result_reg[11:4];
				ADSC_OFF_RESULT_LOW: rdata_next[7:0] =
					timing_reg[ADSC_JUST_BIT] ? result_reg[7:0] :
					{result_reg[3:0], 4'h0};
				ADSC_OFF_CONV_CTRL: rdata_next[7:0] = conv_ctrl_reg;
				ADSC_OFF_PORT_CFG: rdata_next[7:0] = port_cfg_reg;
				ADSC_OFF_TIMING: rdata_next[7:0] = timing_reg;
				ADSC_OFF_STATUS: rdata_next[ADSC_DONE_BIT] = done_reg;
				default: rresp_next = ADSC_RESP_SLVERR; // see (R8)
			endcase
		end
		arready_next = s_axi_arvalid && !arready_reg && !rvalid_next;
	end

	// register writes and the conversion sequencer
	always_comb begin
		conv_ctrl_next = conv_ctrl_reg;
		port_cfg_next = port_cfg_reg;
		timing_next = timing_reg;
		result_next = result_reg;
		done_next = done_reg;
		state_next = state_reg;
		acq_cnt_next = acq_cnt_reg;
		rc_cnt_next = rc_cnt_reg;
		sar_start_next = 1'b0;
		if (do_write && wstrb_reg[0]) begin
			case (awaddr_reg)
				// bits 7..6 unimplemented; start bit only by software set
				ADSC_OFF_CONV_CTRL: begin
					conv_ctrl_next = {2'b00, wdata_reg[5:0]};
					if (state_reg != ADSC_IDLE) begin
						conv_ctrl_next[ADSC_START_BIT] = 1'b1;
					end
					// start ignored while the converter is off; see (R13)
					if (!wdata_reg[ADSC_ENABLE_BIT]) begin
						conv_ctrl_next[ADSC_START_BIT] = 1'b0;
					end
				end
				ADSC_OFF_PORT_CFG: port_cfg_next = {2'b00, wdata_reg[5:0]};
				ADSC_OFF_TIMING: timing_next = {wdata_reg[7], 1'b0,
					wdata_reg[5:0]};
				// writing one clears the done flag
				ADSC_OFF_STATUS: if (wdata_reg[ADSC_DONE_BIT]) begin
					done_next = 1'b0;
				end
				default: ;
			endcase
		end
		case (state_reg)
			ADSC_IDLE: begin
				if (conv_ctrl_next[ADSC_START_BIT] &&
					conv_ctrl_next[ADSC_ENABLE_BIT]) begin
					// rc clock waits one instruction cycle first; see (R12)
					rc_cnt_next = ADSC_RC_DELAY_CYC;
					acq_cnt_next = acq_len;
					state_next = rc_sel ? ADSC_RCWAIT : ADSC_ACQ;
				end
			end
			ADSC_RCWAIT: begin
				rc_cnt_next = rc_cnt_reg - 8'h01;
				if (rc_cnt_reg == 8'h01) begin
					state_next = ADSC_ACQ;
				end
			end
			// programmed acquisition before conversion; see (R7)
			ADSC_ACQ: begin
				if (acq_cnt_reg == 5'd0) begin
					sar_start_next = 1'b1;
					state_next = ADSC_CONV;
				end else if (tick) begin
					acq_cnt_next = acq_cnt_reg - 5'd1;
				end
			end
			ADSC_CONV: begin
				// invalid channel still converts a floating value; see (R3)
				if (sar_done) begin
					result_next = sar_trial; // see (R9)
					conv_ctrl_next[ADSC_START_BIT] = 1'b0; // see (R9)
					done_next = 1'b1; // see (R9)
					state_next = ADSC_IDLE;
				end
			end
			default: state_next = ADSC_IDLE;
		endcase
		// turning the converter off aborts a running conversion
		if (!conv_ctrl_next[ADSC_ENABLE_BIT]) begin
			state_next = ADSC_IDLE;
			conv_ctrl_next[ADSC_START_BIT] = 1'b0;
		end
	end

	// per-input analog map: code 0..2 all analog, each step frees one more
	always_comb begin
		pin_analog_next = '1; // see (R6)
		for (int i = 0; i < ADSC_NUM_INPUTS; i++) begin
			if (port_cfg_reg[ADSC_PCFG_MSB:ADSC_PCFG_LSB] > 4'h2 &&
				(32'(ADSC_NUM_INPUTS - i) <=
				32'(port_cfg_reg[ADSC_PCFG_MSB:ADSC_PCFG_LSB]) - 32'd2)) begin
				pin_analog_next[i] = 1'b0;
			end
		end
	end

	// reset defaults: converter off, sequencer idle; see (R10)
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			conv_ctrl_reg <= ADSC_RST_CONV_CTRL;
			port_cfg_reg <= ADSC_RST_PORT_CFG;
			timing_reg <= ADSC_RST_TIMING;
			result_reg <= ADSC_RST_RESULT;
			done_reg <= 1'b0;
			state_reg <= ADSC_IDLE;
			acq_cnt_reg <= 5'd0;
			rc_cnt_reg <= 8'h00;
			sar_start_reg <= 1'b0;
			pin_analog_reg <= '1;
			awready_reg <= 1'b0;
			wready_reg <= 1'b0;
			aw_held_reg <= 1'b0;
			w_held_reg <= 1'b0;
			awaddr_reg <= 8'h00;
			wdata_reg <= 32'h0000_0000;
			wstrb_reg <= 4'h0;
			bvalid_reg <= 1'b0;
			bresp_reg <= ADSC_RESP_OKAY;
			arready_reg <= 1'b0;
			rvalid_reg <= 1'b0;
			rdata_reg <= 32'h0000_0000;
			rresp_reg <= ADSC_RESP_OKAY;
		end else begin
			conv_ctrl_reg <= conv_ctrl_next;
			port_cfg_reg <= port_cfg_next;
			timing_reg <= timing_next;
			result_reg <= result_next;
			done_reg <= done_next;
			state_reg <= state_next;
			acq_cnt_reg <= acq_cnt_next;
			rc_cnt_reg <= rc_cnt_next;
			sar_start_reg <= sar_start_next;
			pin_analog_reg <= pin_analog_next;
			awready_reg <= awready_next;
			wready_reg <= wready_next;
			aw_held_reg <= aw_held_next;
			w_held_reg <= w_held_next;
			awaddr_reg <= awaddr_next;
			wdata_reg <= wdata_next;
			wstrb_reg <= wstrb_next;
			bvalid_reg <= bvalid_next;
			bresp_reg <= bresp_next;
			arready_reg <= arready_next;
			rvalid_reg <= rvalid_next;
			rdata_reg <= rdata_next;
			rresp_reg <= rresp_next;
		end
	end

	// outputs from flops; chan_valid and sample_hold decoded from flops
	assign s_axi_awready = awready_reg;
	assign s_axi_wready = wready_reg;
	assign s_axi_bvalid = bvalid_reg;
	assign s_axi_bresp = bresp_reg;
	assign s_axi_arready = arready_reg;
	assign s_axi_rvalid = rvalid_reg;
	assign s_axi_rdata = rdata_reg;
	assign s_axi_rresp = rresp_reg;
	assign chan_sel = conv_ctrl_reg[ADSC_CHAN_MSB:ADSC_CHAN_LSB]; // see (R2)
	assign chan_valid = conv_ctrl_reg[ADSC_CHAN_MSB:ADSC_CHAN_LSB] <=
		ADSC_CHAN_LAST; // see (R3)
	assign dac_trial = sar_trial; // see (R1)
	assign sample_hold = (state_reg == ADSC_CONV);
	assign converter_power = conv_ctrl_reg[ADSC_ENABLE_BIT]; // see (R4)
	assign neg_ref_select = port_cfg_reg[ADSC_NREF_BIT]; // see (R5)
	assign pos_ref_select = port_cfg_reg[ADSC_PREF_BIT]; // see (R5)
	assign pin_analog = pin_analog_reg;
	assign conversion_done_flag = done_reg;

endmodule : adsc_ctrl

`default_nettype wire

/* adsc_pkg.sv */
// adsc_pkg: register map, field positions, reset values and timing constants
// of the converter control block.
// assumes a 32-bit axi4-lite slave with one register per aligned word.
`default_nettype none

package adsc_pkg;

	// register byte addresses
	localparam logic [7:0] ADSC_OFF_RESULT_HIGH = 8'h00;
	localparam logic [7:0] ADSC_OFF_RESULT_LOW = 8'h04;
	localparam logic [7:0] ADSC_OFF_CONV_CTRL = 8'h08;
	localparam logic [7:0] ADSC_OFF_PORT_CFG = 8'h0C;
	localparam logic [7:0] ADSC_OFF_TIMING = 8'h10;
	localparam logic [7:0] ADSC_OFF_STATUS = 8'h14;

	// conversion control fields
	localparam int ADSC_ENABLE_BIT = 0;
	localparam int ADSC_START_BIT = 1;
	localparam int ADSC_CHAN_LSB = 2;
	localparam int ADSC_CHAN_MSB = 5;
	localparam logic [3:0] ADSC_CHAN_LAST = 4'hC;

	// port configuration fields
	localparam int ADSC_NREF_BIT = 5;
	localparam int ADSC_PREF_BIT = 4;
	localparam int ADSC_PCFG_LSB = 0;
	localparam int ADSC_PCFG_MSB = 3;

	// timing and format fields
	localparam int ADSC_JUST_BIT = 7;
	localparam int ADSC_ACQ_LSB = 3;
	localparam int ADSC_ACQ_MSB = 5;
	localparam int ADSC_CLK_LSB = 0;
	localparam int ADSC_CLK_MSB = 2;
	localparam logic [2:0] ADSC_CLK_RC = 3'h3;
	localparam logic [2:0] ADSC_CLK_RC_ALT = 3'h7;

	// status register bit
	localparam int ADSC_DONE_BIT = 0;

	// reset values
	localparam logic [7:0] ADSC_RST_CONV_CTRL = 8'h00;
	localparam logic [7:0] ADSC_RST_PORT_CFG = 8'h00;
	localparam logic [7:0] ADSC_RST_TIMING = 8'h00;
	localparam logic [11:0] ADSC_RST_RESULT = 12'h000;

	// widths and counts
	localparam int ADSC_RES_BITS = 12;
	localparam int ADSC_NUM_INPUTS = 13;
	localparam logic [7:0] ADSC_DEF_DIVIDE = 8'h04;

	// internal rc start delay: one instruction cycle
	localparam int ADSC_TCY_NS = 40;
	localparam int ADSC_CLK_NS = 10;
	localparam logic [7:0] ADSC_RC_DELAY_CYC =
		8'((ADSC_TCY_NS + ADSC_CLK_NS - 1) / ADSC_CLK_NS);

	// axi response codes
	localparam logic [1:0] ADSC_RESP_OKAY = 2'h0;
	localparam logic [1:0] ADSC_RESP_SLVERR = 2'h2;

	typedef enum logic [2:0] {
		ADSC_IDLE,
		ADSC_RCWAIT,
		ADSC_ACQ,
		ADSC_CONV
	} adsc_state_e;

endpackage : adsc_pkg

`default_nettype wire

/* adsc_tick_gen.sv */
// adsc_tick_gen: divides aclk into one-cycle bit-time ticks.
// assumes the divide value is held stable while enabled.
`default_nettype none

module adsc_tick_gen (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// control
	input wire logic run,
	input wire logic [7:0] divide,
	// tick out
	output logic tick
);
	import adsc_pkg::*;

	logic [7:0] cnt_reg;
	logic [7:0] cnt_next;
	logic tick_reg;
	logic tick_next;

	// count down from divide-1, pulse at zero; restarts whenever run drops
	always_comb begin
		cnt_next = cnt_reg;
		tick_next = 1'b0;
		if (!run) begin
			cnt_next = divide - 8'h01;
		end else if (cnt_reg == 8'h00) begin
			cnt_next = divide - 8'h01;
			tick_next = 1'b1;
		end else begin
			cnt_next = cnt_reg - 8'h01;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cnt_reg <= 8'h00;
			tick_reg <= 1'b0;
		end else begin
			cnt_reg <= cnt_next;
			tick_reg <= tick_next;
		end
	end

	assign tick = tick_reg;

endmodule : adsc_tick_gen

`default_nettype wire

/* adsc_sar.sv */
// adsc_sar: 12-bit successive-approximation register.
// assumes comp_in is already synchronised and reflects the trial value.
`default_nettype none

module adsc_sar (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// control
	input wire logic start,
	input wire logic step,
	input wire logic comp_in,
	// result
	output logic [11:0] trial,
	output logic done
);
	import adsc_pkg::*;

	logic [11:0] val_reg;
	logic [11:0] val_next;
	logic [11:0] bit_reg;
	logic [11:0] bit_next;
	logic done_reg;
	logic done_next;

	// msb first: keep the trial bit when the comparator says input is above
	always_comb begin
		val_next = val_reg;
		bit_next = bit_reg;
		done_next = 1'b0;
		if (start) begin
			bit_next = 12'h800;
			val_next = 12'h800;
		end else if (step && (bit_reg != 12'h000)) begin
			if (!comp_in) begin
				val_next = val_reg & ~bit_reg;
			end
			bit_next = bit_reg >> 1;
			val_next = val_next | (bit_reg >> 1);
			done_next = (bit_reg == 12'h001);
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			val_reg <= ADSC_RST_RESULT;
			bit_reg <= 12'h000;
			done_reg <= 1'b0;
		end else begin
			val_reg <= val_next;
			bit_reg <= bit_next;
			done_reg <= done_next;
		end
	end

	assign trial = val_reg;
	assign done = done_reg;

endmodule : adsc_sar

`default_nettype wire

/* adsc_ctrl_properties.sv */
// adsc_ctrl_properties: concurrent checks on the converter control ports.
// assumes one clock domain with the synchronous active-low reset.
`default_nettype none

module adsc_ctrl_properties (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// register bus handshakes
	input wire logic s_axi_awready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [1:0] s_axi_rresp,
	// converter side
	input wire logic [3:0] chan_sel,
	input wire logic chan_valid,
	input wire logic sample_hold,
	input wire logic converter_power,
	input wire logic [12:0] pin_analog,
	input wire logic conversion_done_flag
);
	import adsc_pkg::*;

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	// codes past the last input select nothing
	property p_chan_valid;
		chan_valid == (chan_sel <= ADSC_CHAN_LAST);
	endproperty
	a_chan_valid: assert property (p_chan_valid)
		else $error("chan_valid disagrees with chan_sel");
	// digital inputs always fill from the top, so the map is a low run of ones
	property p_pin_run;
		((pin_analog + 13'h0001) & pin_analog) == 13'h0000;
	endproperty
	a_pin_run: assert property (p_pin_run)
		else $error("pin_analog is not a low run of ones");
	// one cycle of slack lets an abort land after the enable drops
	property p_no_power;
		!converter_power && !$past(converter_power) |-> !sample_hold;
	endproperty
	a_no_power: assert property (p_no_power)
		else $error("sampling while powered down");
	property p_done_rise;
		$rose(conversion_done_flag) |-> !sample_hold && converter_power;
	endproperty
	a_done_rise: assert property (p_done_rise)
		else $error("done flag rose during conversion");
	property p_reset_vals;
		$rose(aresetn) |-> !converter_power && !sample_hold &&
			!conversion_done_flag && pin_analog == 13'h1FFF && chan_sel == 4'h0;
	endproperty
	a_reset_vals: assert property (p_reset_vals)
		else $error("outputs not at reset values");
	// a conversion is twelve steps, far longer than eight cycles
	property p_busy_len; $rose(sample_hold) |-> sample_hold [*8]; endproperty
	a_busy_len: assert property (p_busy_len)
		else $error("conversion ended too soon");
	property p_ar_to_r; s_axi_arready |=> s_axi_rvalid; endproperty
	a_ar_to_r: assert property (p_ar_to_r)
		else $error("read data late");
	property p_aw_to_b; s_axi_awready |-> ##[1:3] s_axi_bvalid; endproperty
	a_aw_to_b: assert property (p_aw_to_b)
		else $error("write response late");
	property p_ar_pulse; s_axi_arready |=> !s_axi_arready; endproperty
	a_ar_pulse: assert property (p_ar_pulse)
		else $error("arready longer than one cycle");

	// main scenarios reached
	cover property ($rose(conversion_done_flag));
	cover property ($fell(chan_valid));
	cover property (s_axi_rvalid && s_axi_rready &&
		s_axi_rresp == ADSC_RESP_SLVERR);
	cover property ($rose(sample_hold));
endmodule // adsc_ctrl_properties

bind adsc_ctrl adsc_ctrl_properties i_adsc_ctrl_properties (.aclk, .aresetn,
	.s_axi_awready, .s_axi_bvalid, .s_axi_arready, .s_axi_rvalid,
	.s_axi_rready, .s_axi_rresp, .chan_sel, .chan_valid, .sample_hold,
	.converter_power, .pin_analog, .conversion_done_flag);

`default_nettype wire

/* tb_adsc_ctrl.sv */
// tb_adsc_ctrl: self-checking bench of the converter control block.
// assumes the bench acts as axi4-lite master and as the analog comparator.
`default_nettype none

module tb_adsc_ctrl;
	timeunit 1ns;
	timeprecision 1ps;
	import adsc_pkg::*;
	logic aclk = 1'h0;
	logic aresetn = 1'h0;
	logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0;
	logic rready = 1'h0, comp_in = 1'h0, busy;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0000_0000, d, tv;
	logic [3:0] wstrb = 4'h0, chan_sel;
	logic awready, wready, bvalid, arready, rvalid, chan_valid, sample_hold;
	logic power, nref, pref, done;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	logic [11:0] dac_trial, target = 12'h000;
	logic [12:0] pin_analog;
	logic [15:0] seed = 16'hFEC6;
	logic [34:0] rq[$], e;
	logic [1:0] bq[$];
	int n_mismatch = 0, n_compared = 0, cyc = 0, i, k;

	adsc_ctrl i_adsc_ctrl (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .comp_in(comp_in),
		.chan_sel(chan_sel), .chan_valid(chan_valid), .dac_trial(dac_trial),
		.sample_hold(sample_hold), .converter_power(power),
		.neg_ref_select(nref), .pos_ref_select(pref), .pin_analog(pin_analog),
		.conversion_done_flag(done));

	always #5 aclk = ~aclk;

	// comparator: input sits half a step above target, so the sar lands on it
	always @(posedge aclk) comp_in <= (dac_trial <= target);

	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction

	task check(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task results;
		$display("checks %0d mismatches %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask

	// write: address and data offered together, each dropped once taken
	task wr(input logic [7:0] a, input logic [31:0] x, input logic [1:0] r);
		logic b;
		b = 1'h0;
		@(posedge aclk);
		bq.push_back(r);
		awaddr <= a; awvalid <= 1'h1; wdata <= x; wstrb <= 4'hF;
		wvalid <= 1'h1; bready <= 1'h1;
		while (!b) begin
			@(posedge aclk);
			if (awvalid && awready) awvalid <= 1'h0;
			if (wvalid && wready) wvalid <= 1'h0;
			if (bvalid && bready) begin b = 1'h1; bready <= 1'h0; end
		end
	endtask

	// read: c set means the data is compared, not only the response
	task rd(input logic [7:0] a, input logic c, input logic [1:0] r,
		input logic [31:0] x, output logic [31:0] q);
		logic got;
		got = 1'h0;
		@(posedge aclk);
		rq.push_back({c, r, x});
		araddr <= a; arvalid <= 1'h1; rready <= 1'h1;
		while (!got) begin
			@(posedge aclk);
			if (arvalid && arready) arvalid <= 1'h0;
			if (rvalid && rready) begin got = 1'h1; q = rdata; rready <= 1'h0; end
		end
	endtask

	task rc(input logic [7:0] a, input logic [31:0] x);
		rd(a, 1'h1, ADSC_RESP_OKAY, x, d);
	endtask

	// monitor: oldest note is matched against each response as it lands
	always @(posedge aclk) begin
		if (rvalid && rready) begin
			e = rq.pop_front();
			check("rresp", {30'h0, rresp}, {30'h0, e[33:32]});
			if (e[34]) check("rdata", rdata, e[31:0]);
		end
		if (bvalid && bready) begin
			e = {33'h0, bq.pop_front()};
			check("bresp", {30'h0, bresp}, e[31:0]);
		end
		cyc++;
		if (cyc == 20000) begin n_mismatch++; results(); end
	end

	initial begin
		repeat (6) @(posedge aclk);
		aresetn <= 1'h1;
		check("pins", {19'h0, pin_analog}, 32'h0000_1FFF);
		for (i = 0; i < 6; i++) rc(8'(i * 4), 32'h0000_0000);
		rd(8'h18, 1'h0, ADSC_RESP_SLVERR, 32'h0, d);
		wr(8'h18, 32'h0000_00FF, ADSC_RESP_SLVERR);
		wr(ADSC_OFF_RESULT_HIGH, 32'h0000_00FF, ADSC_RESP_OKAY);
		rc(ADSC_OFF_RESULT_HIGH, 32'h0000_0000);
		wr(ADSC_OFF_TIMING, 32'h0000_00FF, ADSC_RESP_OKAY);
		rc(ADSC_OFF_TIMING, 32'h0000_00BF);
		wr(ADSC_OFF_CONV_CTRL, 32'h0000_00FE, ADSC_RESP_OKAY);
		rc(ADSC_OFF_CONV_CTRL, 32'h0000_003C);
		check("sample_hold", {31'h0, sample_hold}, 32'h0);
		// every channel code, the unmapped ones included
		for (i = 0; i < 16; i++) begin
			wr(ADSC_OFF_CONV_CTRL, 32'(i << 2), ADSC_RESP_OKAY);
			@(posedge aclk);
			check("chan_sel", {28'h0, chan_sel}, 32'(i));
			check("chan_valid", {31'h0, chan_valid}, 32'(i <= 12));
		end
		// every pin map code, reference bits toggling alongside
		for (i = 0; i < 16; i++) begin
			tv = 32'(i | ((i & 3) << 4));
			wr(ADSC_OFF_PORT_CFG, tv, ADSC_RESP_OKAY);
			rc(ADSC_OFF_PORT_CFG, tv);
			tv = (i <= 2) ? 32'h0000_1FFF : 32'h0000_1FFF >> (i - 2);
			check("pin", {19'h0, pin_analog}, tv);
			check("refs", {30'h0, nref, pref}, 32'(i & 3));
		end
		// conversions: both justifications, rc and core clocks, several delays
		for (i = 0; i < 4; i++) begin
			seed = lfsr(seed);
			target = seed[11:0];
			tv = 32'((i[0] << 7) | (i << 3) | (i == 2 ? 3 : i == 3 ? 7 : 0));
			wr(ADSC_OFF_TIMING, tv, ADSC_RESP_OKAY);
			wr(ADSC_OFF_CONV_CTRL, 32'((i << 2) | 3), ADSC_RESP_OKAY);
			busy = 1'h1;
			k = 0;
			while (busy && k < 200) begin
				rd(ADSC_OFF_CONV_CTRL, 1'h0, ADSC_RESP_OKAY, 32'h0, d);
				busy = d[1];
				k++;
			end
			check("ctrl_end", d, 32'((i << 2) | 1));
			check("done", {31'h0, done}, 32'h1);
			rc(ADSC_OFF_STATUS, 32'h0000_0001);
			tv = i[0] ? {28'h0, target[11:8]} : {24'h0, target[11:4]};
			rc(ADSC_OFF_RESULT_HIGH, tv);
			tv = i[0] ? {24'h0, target[7:0]} : {24'h0, target[3:0], 4'h0};
			rc(ADSC_OFF_RESULT_LOW, tv);
			wr(ADSC_OFF_STATUS, 32'h0000_0001, ADSC_RESP_OKAY);
			check("done_clr", {31'h0, done}, 32'h0);
			repeat (8) @(posedge aclk);
		end
		// rc clock start lags the core clock start by one instruction cycle
		tv = 32'h0000_0000;
		for (i = 0; i < 2; i++) begin
			wr(ADSC_OFF_TIMING, 32'(i * 3), ADSC_RESP_OKAY);
			wr(ADSC_OFF_CONV_CTRL, 32'h0000_0003, ADSC_RESP_OKAY);
			k = 0;
			while (!sample_hold && k < 50) begin
				@(posedge aclk);
				k++;
			end
			tv = 32'(k) - tv;
			while (!done) @(posedge aclk);
			wr(ADSC_OFF_STATUS, 32'h0000_0001, ADSC_RESP_OKAY);
			repeat (8) @(posedge aclk);
		end
		check("rc_delay", tv, 32'(ADSC_RC_DELAY_CYC));
		// abort by clearing the enable, then by reset mid-conversion
		wr(ADSC_OFF_TIMING, 32'h0000_0038, ADSC_RESP_OKAY);
		wr(ADSC_OFF_CONV_CTRL, 32'h0000_0003, ADSC_RESP_OKAY);
		repeat (100) @(posedge aclk);
		check("running", {31'h0, sample_hold}, 32'h1);
		wr(ADSC_OFF_CONV_CTRL, 32'h0000_0000, ADSC_RESP_OKAY);
		rc(ADSC_OFF_CONV_CTRL, 32'h0000_0000);
		check("abort", {30'h0, sample_hold, done}, 32'h0);
		wr(ADSC_OFF_CONV_CTRL, 32'h0000_0003, ADSC_RESP_OKAY);
		repeat (100) @(posedge aclk);
		check("running", {31'h0, sample_hold}, 32'h1);
		aresetn <= 1'h0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'h1;
		rc(ADSC_OFF_CONV_CTRL, 32'h0000_0000);
		rc(ADSC_OFF_TIMING, 32'h0000_0000);
		check("power", {31'h0, power}, 32'h0);
		results();
	end
endmodule // tb_adsc_ctrl

`default_nettype wire
